// ---- core/lcdid_pkg.sv ----
package lcdid_pkg;

    // ------------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------------
    localparam int          CMD_W         = 16;
    localparam int          BITCNT_W      = 5;
    localparam logic [4:0]  BIT_LAST      = 5'h0f;   // Index of the sixteenth bit.
    localparam logic [4:0]  BIT_FULL      = 5'h10;   // Counter parks here once full.

    typedef struct packed {
        logic [1:0] target;                          // Chip target select, hi then lo.
        logic [5:0] opcode;                          // Command selector.
        logic [7:0] data;                            // Argument bits.
    } lcdid_cmd_t;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [5:0]  OP_ENTRY      = 6'h08;
    localparam logic [5:0]  OP_DISP_SHIFT = 6'h0a;
    localparam logic [5:0]  OP_STATIC     = 6'h0b;
    localparam logic [5:0]  OP_CONTRAST   = 6'h0c;
    localparam logic [5:0]  OP_DOT_SHIFT  = 6'h0d;
    localparam logic [5:0]  OP_DISP_MODE  = 6'h0e;
    localparam logic [5:0]  OP_GLYPH_ADDR = 6'h10;
    localparam logic [5:0]  OP_TEXT_ADDR  = 6'h13;
    localparam logic [5:0]  OP_WRITE_DATA = 6'h18;

    // Data bit positions.
    localparam int          BIT_ENTRY_INC = 1;
    localparam int          BIT_ENTRY_SHF = 0;
    localparam int          BIT_SHIFT_DIR = 0;
    localparam int          BIT_KEY_SCAN  = 1;
    localparam int          BIT_SLEEP     = 0;
    localparam int          BIT_ICON_SEL  = 4;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [7:0]  TEXT_LAST     = 8'h0d;
    localparam logic [7:0]  ICON_BASE     = 8'h10;
    localparam logic [7:0]  ICON_SHOWN    = 8'h1b;   // 1c and 1d are not displayed.
    localparam logic [7:0]  GLYPH_LAST    = 8'hfe;
    localparam logic [7:0]  ADDR_STEP     = 8'h01;
    localparam int          TEXT_DEPTH    = 14;
    localparam int          ICON_DEPTH    = 12;
    localparam int          GLYPH_DEPTH   = 255;
    localparam int          TEXT_W        = 8;
    localparam int          PIX_W         = 5;

    typedef enum logic [1:0] {
        RAM_TEXT  = 2'b00,
        RAM_ICON  = 2'b01,
        RAM_GLYPH = 2'b10
    } lcdid_ram_t;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0]  RST_STATIC    = 4'h0;
    localparam logic [3:0]  RST_CONTRAST  = 4'h0;
    localparam logic [2:0]  RST_DOT       = 3'h0;
    localparam logic [3:0]  RST_SHIFT_POS = 4'h0;
    localparam logic [7:0]  RST_ADDR      = 8'h00;
    localparam logic [1:0]  MS_ID_DEF     = 2'b00;

endpackage : lcdid_pkg

// ---- core/lcdid_ram.sv ----
// ----------------------------------------------------------------------
// Small write/read memory with registered read data
// ----------------------------------------------------------------------
module lcdid_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 14,
    parameter int AW    = 4
) (
    input  wire logic             clk,     // Core clock.
    input  wire logic             wrEn,    // Write strobe.
    input  wire logic [AW-1:0]    wrAddr,  // Write address.
    input  wire logic [WIDTH-1:0] wrData,  // Write data.
    input  wire logic [AW-1:0]    rdAddr,  // Read address.
    output logic      [WIDTH-1:0] rdData   // Read data, one cycle after address.
);

    // Refuse an address width too narrow for the depth.
    if (DEPTH > (1 << AW)) begin : g_chk
        $error("lcdid_ram: AW too small for DEPTH");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Contents are not reset; software loads them before display.
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule : lcdid_ram

// ---- core/lcdid_decoder.sv ----
// Notes on behaviour
// - Static port command copies data bits 3..0 to the four static outputs.
// - Static outputs are low from reset until a static port command.
// - Contrast command loads a 4-bit step, 0 lowest, 15 highest.
// - Dot-shift command stores a 3-bit left shift; 0 none, 6 and 7 don't-care.
// - Smooth scroll combines dot offset with whole-display shift position.
// - A display shift command clears the dot offset.
// - Dot offset applies to character columns only, never icons.
// - Display mode bit 1 enables key scan, bit 0 enters sleep.
// - Sleep drives all common and segment outputs to the top level.
// - Sleep during a key scan aborts it for the rest of that period.
// - A key request raised before sleep stays high after release.
// - Key data after an abort is invalid until the next completed scan.
// - Text/icon address command loads 5 bits; 00-0d text, 10-1d icon.
// - Glyph address command loads 8 bits, 00-fe, into the glyph RAM.
// - Data write stores 8 bits to text or 5 bits to glyph/icon.
// - After each write the address counter steps by plus or minus one.
// - After each text RAM write the display shifts when entry mode enables it.
// - Icon writes at 1c and 1d change nothing but still step the address.
// - Text, icon and glyph addresses step by the entry direction bit.
// - Each command is one 16-bit word, most significant bit first.
// - Bits past sixteen are ignored; short frames are dropped at select rise.
module lcdid_decoder #(
    parameter logic [1:0] MS_ID = lcdid_pkg::MS_ID_DEF
) (
    input  wire logic       clk,            // Core clock, 10 MHz.
    input  wire logic       rst_b,          // Asynchronous reset, active low.
    input  wire logic       sck,            // Serial shift clock from the host.
    input  wire logic       csB,            // Serial chip select, active low.
    input  wire logic       sdi,            // Serial data in.
    input  wire logic       keyScanBusy,    // Key scan engine is mid-scan.
    input  wire logic       keyScanDone,    // Pulse: a scan completed.
    input  wire logic       keyHit,         // Pulse: a key press was found.
    input  wire logic       keyFrameStart,  // Pulse: a new scan period begins.
    input  wire logic       keyReqClr,      // Pulse: key data were read.
    input  wire logic [3:0] textRdAddr,     // Display read address, text.
    input  wire logic [3:0] iconRdAddr,     // Display read address, icons.
    input  wire logic [7:0] glyphRdAddr,    // Display read address, glyphs.
    output logic      [3:0] staticOut,      // Static indicator outputs.
    output logic      [3:0] contrast,       // Drive voltage step.
    output logic      [2:0] charDotOffset,  // Left dot offset for characters.
    output logic      [3:0] dispShiftPos,   // Whole-display shift position.
    output logic            entryInc,       // Entry direction, 1 increment.
    output logic            entryShift,     // Entry shift on write.
    output logic            keyScanRun,     // Key scan permitted to run.
    output logic            sleepMode,      // All drive outputs at top level.
    output logic            keyReq,         // Key request output.
    output logic            keyDataValid,   // Key data are valid to read.
    output logic            scanAbort,      // Pulse: current scan aborted.
    output logic      [7:0] addrCounter,    // Address counter.
    output logic      [7:0] textRdData,     // Text RAM read data.
    output logic      [4:0] iconRdData,     // Icon RAM read data.
    output logic      [4:0] glyphRdData     // Glyph RAM read data.
);

    // ------------------------------------------------------------------
    // Serial link domain
    // ------------------------------------------------------------------
    logic [lcdid_pkg::BITCNT_W-1:0] bitCnt_ff;
    logic [lcdid_pkg::CMD_W-1:0]    shift_ff;
    logic [lcdid_pkg::CMD_W-1:0]    wordHold_ff;
    logic                           wordTgl_ff;
    wire                            linkRst_b = rst_b & ~csB;
    wire                            bitLast   = (bitCnt_ff == lcdid_pkg::BIT_LAST);
    wire                            bitFull   = (bitCnt_ff == lcdid_pkg::BIT_FULL);
    // The bit counter ends with the frame: chip select high clears it, so
    // no sck edge is needed after the last bit.
    // ignore extra bits
    always_ff @(posedge sck or negedge linkRst_b) begin
        if (!linkRst_b) begin
            bitCnt_ff <= '0;
        end else if (!bitFull) begin
            bitCnt_ff <= bitCnt_ff + 5'h01;
        end
    end
    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            shift_ff <= '0;
        end else begin
            shift_ff <= {shift_ff[lcdid_pkg::CMD_W-2:0], sdi};
        end
    end
    // The held word only changes on the sixteenth bit, so it stays stable
    // for the core to read long after the toggle has crossed.
    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            wordHold_ff <= '0;
            wordTgl_ff  <= 1'b0;
        end else if (bitLast && !csB) begin
            wordHold_ff <= {shift_ff[lcdid_pkg::CMD_W-2:0], sdi};
            wordTgl_ff  <= ~wordTgl_ff;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the core domain
    // ------------------------------------------------------------------
    logic [2:0] tglSync_ff;
    logic [3:0] csSync_ff;
    logic       pending_ff;
    // Select gets one extra stage so a full word always lands first.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tglSync_ff <= '0;
            csSync_ff  <= 4'hf;
        end else begin
            tglSync_ff <= {tglSync_ff[1:0], wordTgl_ff};
            csSync_ff  <= {csSync_ff[2:0], csB};
        end
    end
    wire wordArrive = tglSync_ff[2] ^ tglSync_ff[1];
    wire csRise     = csSync_ff[2] & ~csSync_ff[3];
    wire   nxt_pending = (pending_ff | wordArrive) & ~csRise;
    wire   commit      = csRise & (pending_ff | wordArrive);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_ff <= 1'b0;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    lcdid_pkg::lcdid_cmd_t cmd;
    assign cmd = lcdid_pkg::lcdid_cmd_t'(wordHold_ff);
    wire exec        = commit & (cmd.target == MS_ID);
    wire isEntry     = exec & (cmd.opcode == lcdid_pkg::OP_ENTRY);
    wire isDispShift = exec & (cmd.opcode == lcdid_pkg::OP_DISP_SHIFT);
    wire isStatic    = exec & (cmd.opcode == lcdid_pkg::OP_STATIC);
    wire isContrast  = exec & (cmd.opcode == lcdid_pkg::OP_CONTRAST);
    wire isDotShift  = exec & (cmd.opcode == lcdid_pkg::OP_DOT_SHIFT);
    wire isMode      = exec & (cmd.opcode == lcdid_pkg::OP_DISP_MODE);
    wire isGlyphAddr = exec & (cmd.opcode == lcdid_pkg::OP_GLYPH_ADDR);
    wire isTextAddr  = exec & (cmd.opcode == lcdid_pkg::OP_TEXT_ADDR);
    wire isWrite     = exec & (cmd.opcode == lcdid_pkg::OP_WRITE_DATA);

    logic [3:0] staticOut_ff;
    logic [3:0] contrast_ff;
    logic       entryInc_ff;
    logic       entryShift_ff;
    logic       keyScanEn_ff;
    logic       sleep_ff;
    // static outputs, low at reset, contrast step
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            staticOut_ff <= lcdid_pkg::RST_STATIC;
            contrast_ff  <= lcdid_pkg::RST_CONTRAST;
        end else begin
            if (isStatic)   staticOut_ff <= cmd.data[3:0];
            if (isContrast) contrast_ff  <= cmd.data[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            entryInc_ff   <= 1'b1;
            entryShift_ff <= 1'b0;
            keyScanEn_ff  <= 1'b0;
            sleep_ff      <= 1'b0;
        end else begin
            if (isEntry) begin
                entryInc_ff   <= cmd.data[lcdid_pkg::BIT_ENTRY_INC];
                entryShift_ff <= cmd.data[lcdid_pkg::BIT_ENTRY_SHF];
            end
            if (isMode) begin
                keyScanEn_ff <= cmd.data[lcdid_pkg::BIT_KEY_SCAN];
                sleep_ff     <= cmd.data[lcdid_pkg::BIT_SLEEP];
            end
        end
    end

    // ------------------------------------------------------------------
    // Address counter and RAM writes
    // ------------------------------------------------------------------
    lcdid_pkg::lcdid_ram_t target_ff;
    logic [7:0]            acc_ff;
    wire [7:0] accPlus   = acc_ff + lcdid_pkg::ADDR_STEP;
    wire [7:0] accMinus  = acc_ff - lcdid_pkg::ADDR_STEP;
    wire [7:0] accStep   = entryInc_ff ? accPlus : accMinus;
    // Text and icon addresses wrap within their five-bit field.
    wire [7:0] accNext   = (target_ff == lcdid_pkg::RAM_GLYPH) ? accStep
                                                                : {3'b000, accStep[4:0]};
    wire [7:0] iconOff   = acc_ff - lcdid_pkg::ICON_BASE;
    // write target, hidden icon cells skipped
    wire textWr  = isWrite & (target_ff == lcdid_pkg::RAM_TEXT)
                           & (acc_ff <= lcdid_pkg::TEXT_LAST);
    wire iconWr  = isWrite & (target_ff == lcdid_pkg::RAM_ICON)
                           & (acc_ff >= lcdid_pkg::ICON_BASE)
                           & (acc_ff <= lcdid_pkg::ICON_SHOWN);
    wire glyphWr = isWrite & (target_ff == lcdid_pkg::RAM_GLYPH)
                           & (acc_ff <= lcdid_pkg::GLYPH_LAST);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_ff    <= lcdid_pkg::RST_ADDR;
            target_ff <= lcdid_pkg::RAM_TEXT;
        end else if (isTextAddr) begin
            acc_ff    <= {3'b000, cmd.data[4:0]};
            target_ff <= cmd.data[lcdid_pkg::BIT_ICON_SEL] ? lcdid_pkg::RAM_ICON
                                                           : lcdid_pkg::RAM_TEXT;
        end else if (isGlyphAddr) begin
            acc_ff    <= cmd.data;
            target_ff <= lcdid_pkg::RAM_GLYPH;
        end else if (isWrite) begin
            acc_ff    <= accNext;
        end
    end

    // The three memories share the write data; hidden icon cells never reach one.
    lcdid_ram #(.WIDTH(lcdid_pkg::TEXT_W), .DEPTH(lcdid_pkg::TEXT_DEPTH), .AW(4)) u_text (
        .clk(clk), .wrEn(textWr), .wrAddr(acc_ff[3:0]), .wrData(cmd.data),
        .rdAddr(textRdAddr), .rdData(textRdData));
    lcdid_ram #(.WIDTH(lcdid_pkg::PIX_W), .DEPTH(lcdid_pkg::ICON_DEPTH), .AW(4)) u_icon (
        .clk(clk), .wrEn(iconWr), .wrAddr(iconOff[3:0]), .wrData(cmd.data[4:0]),
        .rdAddr(iconRdAddr), .rdData(iconRdData));
    lcdid_ram #(.WIDTH(lcdid_pkg::PIX_W), .DEPTH(lcdid_pkg::GLYPH_DEPTH), .AW(8)) u_glyph (
        .clk(clk), .wrEn(glyphWr), .wrAddr(acc_ff), .wrData(cmd.data[4:0]),
        .rdAddr(glyphRdAddr), .rdData(glyphRdData));

    // ------------------------------------------------------------------
    // Smooth scroll
    // ------------------------------------------------------------------
    logic [2:0] dot_ff;
    logic [3:0] shiftPos_ff;

    // shift on write, text RAM only
    wire writeShift = isWrite & entryShift_ff & (target_ff == lcdid_pkg::RAM_TEXT);
    wire cmdLeft    = isDispShift & ~cmd.data[lcdid_pkg::BIT_SHIFT_DIR];
    wire cmdRight   = isDispShift & cmd.data[lcdid_pkg::BIT_SHIFT_DIR];
    wire goLeft     = cmdLeft | (writeShift & entryInc_ff);
    wire goRight    = cmdRight | (writeShift & ~entryInc_ff);

    // whole-character part of the scroll position
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shiftPos_ff <= lcdid_pkg::RST_SHIFT_POS;
        end else if (goLeft) begin
            shiftPos_ff <= shiftPos_ff + 4'h1;
        end else if (goRight) begin
            shiftPos_ff <= shiftPos_ff - 4'h1;
        end
    end

    // Codes 6 and 7 are stored as given; the display treats them as
    // don't-care, so no clamping is spent on them.
    // dot count, cleared by display shift
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dot_ff <= lcdid_pkg::RST_DOT;
        end else if (isDispShift) begin
            dot_ff <= lcdid_pkg::RST_DOT;
        end else if (isDotShift) begin
            dot_ff <= cmd.data[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Key scan supervision
    // ------------------------------------------------------------------
    logic scanHold_ff;
    logic keyReq_ff;
    logic keyValid_ff;
    logic abort_ff;
    logic scanRun_ff;

    wire abortNow = isMode & cmd.data[lcdid_pkg::BIT_SLEEP] & ~sleep_ff & keyScanBusy;
    wire holdDone = keyFrameStart & ~sleep_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scanHold_ff <= 1'b0;
            abort_ff    <= 1'b0;
            scanRun_ff  <= 1'b0;
        end else begin
            scanHold_ff <= abortNow | (scanHold_ff & ~holdDone);
            abort_ff    <= abortNow;
            scanRun_ff  <= keyScanEn_ff & ~sleep_ff & ~scanHold_ff & ~abortNow;
        end
    end

    // A new press wins over a clear in the same cycle; sleep never clears.
    // request survives sleep
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            keyReq_ff <= 1'b0;
        end else if (keyHit && !sleep_ff && !scanHold_ff) begin
            keyReq_ff <= 1'b1;
        end else if (keyReqClr) begin
            keyReq_ff <= 1'b0;
        end
    end

    // valid only after next full scan
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            keyValid_ff <= 1'b0;
        end else if (abortNow) begin
            keyValid_ff <= 1'b0;
        end else if (keyScanDone && !sleep_ff && !scanHold_ff) begin
            keyValid_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign staticOut     = staticOut_ff;
    assign contrast      = contrast_ff;
    assign charDotOffset = dot_ff;
    assign dispShiftPos  = shiftPos_ff;
    assign entryInc      = entryInc_ff;
    assign entryShift    = entryShift_ff;
    assign keyScanRun    = scanRun_ff;
    assign sleepMode     = sleep_ff;
    assign keyReq        = keyReq_ff;
    assign keyDataValid  = keyValid_ff;
    assign scanAbort     = abort_ff;
    assign addrCounter   = acc_ff;

endmodule : lcdid_decoder

// ---- tb/lcdid_properties.sv ----
// ----------------------------------------------------------------
// Port checker for the decoder
// ----------------------------------------------------------------
module lcdid_properties (
    input wire logic       clk,           // Clock.
    input wire logic       rst_b,         // Reset.
    input wire logic       csB,           // Select.
    input wire logic       keyHit,        // Key found.
    input wire logic       keyScanDone,   // Scan end.
    input wire logic       keyReqClr,     // Key read.
    input wire logic [3:0] staticOut,     // Pins.
    input wire logic [3:0] contrast,      // Step.
    input wire logic [2:0] charDotOffset, // Dots.
    input wire logic [3:0] dispShiftPos,  // Shift.
    input wire logic       entryShift,    // Write shift.
    input wire logic       keyScanRun,    // Scan on.
    input wire logic       sleepMode,     // Sleep.
    input wire logic       keyReq,        // Request.
    input wire logic       keyDataValid,  // Valid.
    input wire logic       scanAbort      // Abort.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Settings move only once a frame has closed, so a partial word never leaks out.
    static_commit_a: assert property ($changed({staticOut, contrast}) |-> $past(csB, 2))
        else $error("setting changed inside a frame");
    sleep_commit_a: assert property ($changed(sleepMode) |-> $past(csB, 2) && $past(csB, 3))
        else $error("sleep changed inside a frame");
    dot_clear_a: assert property ($changed(dispShiftPos) && !entryShift |-> charDotOffset == 3'h0)
        else $error("dot offset kept after display shift");
    abort_sleep_a: assert property (scanAbort |-> $rose(sleepMode))
        else $error("abort without sleep entry");
    abort_pulse_a: assert property (scanAbort |=> !scanAbort && !keyDataValid)
        else $error("abort too long or data still valid");
    sleep_scan_a: assert property (sleepMode |=> !keyScanRun)
        else $error("scan running in sleep");
    keyreq_hold_a: assert property (keyReq && !keyReqClr |=> keyReq)
        else $error("key request dropped");
    keyreq_cause_a: assert property ($rose(keyReq) |-> $past(keyHit))
        else $error("key request without key");
    valid_cause_a: assert property ($rose(keyDataValid) |-> $past(keyScanDone))
        else $error("key data valid without scan");
endmodule : lcdid_properties

// ---- tb/lcdid_host.sv ----
// ----------------------------------------------------------------
// Serial host model
// ----------------------------------------------------------------
module lcdid_host (
    output logic sck, // Shift clock.
    output logic csB, // Select, low.
    output logic sdi  // Serial data.
);
    timeunit 1ns;
    timeprecision 1ps;
    // The shift clock rests low between frames; it runs only in a frame.
    initial begin
        sck = 1'b0;
        csB = 1'b1;
        sdi = 1'b0;
    end
    task automatic send(input logic [15:0] w, input int n);
        csB = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            sdi = (i < 16) ? w[4'(15 - i)] : ~sdi;
            #32 sck = 1'b1;
            #32 sck = 1'b0;
        end
        #250 csB = 1'b1;
        sdi = ~sdi; // Released line shows no stale bit.
        #900;
    endtask : send
endmodule : lcdid_host

// ---- tb/lcdid_decoder_tb.sv ----
bind lcdid_decoder lcdid_properties i_lcdid_properties (
    .clk(clk), .rst_b(rst_b), .csB(csB), .keyHit(keyHit), .keyScanDone(keyScanDone),
    .keyReqClr(keyReqClr), .staticOut(staticOut), .contrast(contrast),
    .charDotOffset(charDotOffset), .dispShiftPos(dispShiftPos), .entryShift(entryShift),
    .keyScanRun(keyScanRun), .sleepMode(sleepMode), .keyReq(keyReq),
    .keyDataValid(keyDataValid), .scanAbort(scanAbort));
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module lcdid_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_b, sck, csB, sdi, busy, done, hit, frm, clr;
    logic       eInc, eShf, run, slp, req, vld, abt;
    logic       abtSeen = 1'b0;
    logic [2:0] dot;
    logic [3:0] stOut, ctr, shPos, txA, icA;
    logic [4:0] glD, icD;
    logic [7:0] acc, txD, glA;
    int         n_errors = 0;
    int         total_checks = 0;
    always #50 clk = ~clk;
    lcdid_decoder i_lcdid_decoder (
        .clk(clk), .rst_b(rst_b), .sck(sck), .csB(csB), .sdi(sdi),
        .keyScanBusy(busy), .keyScanDone(done), .keyHit(hit), .keyFrameStart(frm),
        .keyReqClr(clr), .textRdAddr(txA), .iconRdAddr(icA), .glyphRdAddr(glA),
        .staticOut(stOut), .contrast(ctr), .charDotOffset(dot), .dispShiftPos(shPos),
        .entryInc(eInc), .entryShift(eShf), .keyScanRun(run), .sleepMode(slp),
        .keyReq(req), .keyDataValid(vld), .scanAbort(abt), .addrCounter(acc),
        .textRdData(txD), .iconRdData(icD), .glyphRdData(glD));
    lcdid_host i_lcdid_host (.sck(sck), .csB(csB), .sdi(sdi));
    // Abort lasts one cycle; a sticky copy lets a later compare see it.
    always @(posedge clk) begin
        if (abt === 1'b1) abtSeen <= 1'b1;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk
    // One word per frame; the host returns once the word has surely landed.
    task automatic cmd(input logic [5:0] op, input logic [7:0] d, input int n = 16,
                       input logic [1:0] tg = 2'b00);
        @(posedge clk);
        #5;
        i_lcdid_host.send({tg, op, d}, n);
    endtask : cmd
    task automatic pulse(ref logic s);
        @(posedge clk);
        #5 s = 1'b1;
        @(posedge clk);
        #5 s = 1'b0;
    endtask : pulse
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // Twenty-four frames are planned; the bound leaves ample slack.
    initial begin
        #500us;
        n_errors++;
        $display("wrong value watchdog: expected finish, seen hang");
        end_sim();
    end
    // Reset, then tests as sequences of command calls and compares.
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        {busy, done, hit, frm, clr} = 5'h00;
        txA = 4'h0;
        icA = 4'h0;
        glA = 8'h00;
        repeat (10) @(posedge clk);
        #5 rst_b = 1'b1;
        chk("staticOut", stOut, 8'h00);
        cmd(6'h0b, 8'hf5);
        chk("staticOut", stOut, 8'h05);
        cmd(6'h0b, 8'h0a, 15);
        chk("staticOut", stOut, 8'h05);
        cmd(6'h0b, 8'h03, 20);
        chk("staticOut", stOut, 8'h03);
        cmd(6'h0b, 8'h0c, 16, 2'b01);
        chk("staticOut", stOut, 8'h03);
        cmd(6'h0c, 8'h0f);
        chk("contrast", ctr, 8'h0f);
        cmd(6'h0c, 8'h00);
        chk("contrast", ctr, 8'h00);
        $display("test settings done");
        cmd(6'h08, 8'h02);
        chk("entryShift", eShf, 8'h00);
        cmd(6'h0d, 8'h05);
        chk("charDotOffset", dot, 8'h05);
        cmd(6'h0a, 8'h00);
        chk("dispShiftPos", shPos, 8'h01);
        chk("charDotOffset", dot, 8'h00);
        $display("test scroll done");
        cmd(6'h13, 8'h0d);
        cmd(6'h18, 8'ha5);
        chk("addrCounter", acc, 8'h0e);
        @(posedge clk) #5 txA = 4'hd;
        repeat (2) @(posedge clk);
        #5 chk("textRdData", txD, 8'ha5);
        cmd(6'h08, 8'h00);
        cmd(6'h13, 8'h1c);
        cmd(6'h18, 8'h1f);
        chk("addrCounter", acc, 8'h1b);
        cmd(6'h18, 8'hea);
        @(posedge clk) #5 icA = 4'hb;
        repeat (2) @(posedge clk);
        #5 chk("iconRdData", icD, 8'h0a);
        cmd(6'h10, 8'hfe);
        cmd(6'h18, 8'h15);
        chk("addrCounter", acc, 8'hfd);
        @(posedge clk) #5 glA = 8'hfe;
        repeat (2) @(posedge clk);
        #5 chk("glyphRdData", glD, 8'h15);
        cmd(6'h08, 8'h03);
        chk("entryInc", eInc, 8'h01);
        chk("entryShift", eShf, 8'h01);
        cmd(6'h13, 8'h02);
        cmd(6'h18, 8'h41);
        chk("dispShiftPos", shPos, 8'h02);
        chk("addrCounter", acc, 8'h03);
        $display("test memory done");
        cmd(6'h0e, 8'h02);
        chk("keyScanRun", run, 8'h01);
        pulse(done);
        pulse(hit);
        @(posedge clk) #5 busy = 1'b1;
        cmd(6'h0e, 8'h03);
        chk("sleepMode", slp, 8'h01);
        chk("scanAbort", abtSeen, 8'h01);
        chk("keyDataValid", vld, 8'h00);
        @(posedge clk) #5 busy = 1'b0;
        // Only the release word is sent while asleep.
        cmd(6'h0e, 8'h02);
        chk("keyReq", req, 8'h01);
        chk("keyScanRun", run, 8'h00);
        pulse(done);
        chk("keyDataValid", vld, 8'h00);
        pulse(frm);
        pulse(done);
        chk("keyDataValid", vld, 8'h01);
        pulse(clr);
        chk("keyReq", req, 8'h00);
        cmd(6'h0e, 8'h01);
        chk("sleepMode", slp, 8'h01);
        $display("test keys done");
        end_sim();
    end
endmodule : lcdid_decoder_tb
